// ### fifo_port_defs.svh
// Register offsets, field positions and timing counts for the endpoint buffer access port.
`ifndef FIFO_PORT_DEFS_SVH
`define FIFO_PORT_DEFS_SVH
`define OFS_CMD_STATUS 8'h46
`define OFS_CTRL_DATA 8'h48
`define OFS_INTR_DATA 8'h49
`define BIT_REQUEST 0
`define BIT_TX 1
`define BIT_CLEAR 2
`define BIT_SEL_LOW 3
`define BIT_SEL_HIGH 4
`define BIT_SETUP 5
`define BIT_READY 6
`define BIT_ZLEN 7
`define BUF_DEPTH 8
`define CLK_MHZ 50
`define WAIT_US 2
`define WAIT_CYCLES (`WAIT_US * `CLK_MHZ)
`endif

// ### fifo_port_pkg.sv
// Types shared by both ends of the endpoint buffer access port.
package fifo_port_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [7:0] addr_t;
   typedef enum logic [1:0] {
      SEL_CTRL = 2'h0,
      SEL_INTR = 2'h1
   } sel_t;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_WR = 4'h2,
      ST_WAIT = 4'h4,
      ST_RD = 4'h8
   } host_st_t;
endpackage

// ### fifo_port_if.sv
// Register access link between the processor-side master and the buffer port.
`timescale 1ns/1ns
interface fifo_port_if;
   import fifo_port_pkg::*;
   // Register access strobes and data.
   logic wr;
   logic rd;
   addr_t addr;
   byte_t wdata;
   byte_t rdata;
   modport dev (input wr, input rd, input addr, input wdata, output rdata);
   modport mcu (output wr, output rd, output addr, output wdata, input rdata);
endinterface

// ### skid_buf.sv
// Two-entry valid/ready buffer.
`timescale 1ns/1ns
module skid_buf #(
   parameter int WIDTH = 8
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_n,
   // Filling side.
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Draining side.
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] mem_q [2];
   logic rd_q, wr_q;
   logic [1:0] cnt_q;
   logic push, pop;

   // Full and empty come straight from the occupancy count.
   assign in_ready = (cnt_q != 2'h2);
   assign out_valid = (cnt_q != 2'h0);
   assign out_data = mem_q[rd_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Storage is written only, so it needs no reset.
   always_ff @(posedge clock) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   // Pointers and count.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         cnt_q <= 2'h0;
      end else begin
         if (push) begin
            wr_q <= ~wr_q;
         end
         if (pop) begin
            rd_q <= ~rd_q;
         end
         cnt_q <= 2'(cnt_q + {1'b0, push} - {1'b0, pop});
      end
   end
endmodule

// ### fifo_port_dev.sv
// Device end: command/status register, two eight-byte endpoint buffers and the serial engine side.
`timescale 1ns/1ns
`include "fifo_port_defs.svh"
// How it works
// - Request bit claims the selected buffer
// - Direction bit marks write or read end
// - Clear bit empties the selected buffer
// - Select 00 control, 01 interrupt buffer
// - Setup flag set by engine, firmware clears
// - Ready shows selected buffer accessible now
// - Zero-length flag cleared by buffer read
// - Next setup token clears zero-length flag
// - Two eight-byte buffers, one data port each
// - Firmware read sequence ends with direction high
// - Firmware write sequence ends with direction low
// - At most eight bytes, firmware counts
// - Firmware waits 2 us before polling ready
// - Data port accesses spaced 2 us apart
// - Empty packet sent via command values only
// - Interrupt buffer write command value sequence
// - Host-busy endpoint blocks processor ready
// - Host completion pulses interrupt with endpoint
// - Accessed bitmap set after host access
module fifo_port_dev #(
   parameter int DEPTH = `BUF_DEPTH
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_n,
   // Processor register link.
   fifo_port_if.dev bus,
   // Serial engine byte stream into the buffers.
   input wire logic sie_in_valid,
   output logic sie_in_ready,
   input wire logic sie_in_ep,
   input fifo_port_pkg::byte_t sie_in_data,
   // Serial engine events.
   input wire logic sie_busy_ctrl,
   input wire logic sie_busy_intr,
   input wire logic sie_setup,
   input wire logic sie_zero_len,
   input wire logic sie_done,
   input wire logic sie_done_ep,
   input wire logic sie_take,
   input wire logic sie_take_ep,
   // Serial engine copy of byte 0 of the buffer chosen by sie_take_ep, registered.
   output fifo_port_pkg::byte_t sie_out_data,
   // Processor-facing interrupt and endpoint report.
   output logic usb_int,
   output logic accessed_endpoint_number,
   output logic [1:0] accessed_bitmap
);
   import fifo_port_pkg::*;

   localparam int PW = $clog2(DEPTH + 1);

   byte_t cmd_q;
   byte_t mem_q [2][DEPTH];
   logic [PW-1:0] ptr_q [2];
   logic [PW-1:0] len_q [2];
   logic setup_q, zlen_q, int_q, aen_q;
   logic [1:0] bitmap_q;
   byte_t rdata_q, sout_q;
   logic sel, ready, cmd_wr, data_hit, port_sel, acc;
   logic b_valid, b_ep, take_in, req_tx_q;
   byte_t b_data;
   logic [PW-1:0] lim;

   // The engine writes through the two-entry buffer, so a stalled port never drops a byte.
   skid_buf #(.WIDTH(9)) u_in (
      .clock(clock),
      .rst_n(rst_n),
      .in_valid(sie_in_valid),
      .in_ready(sie_in_ready),
      .in_data({sie_in_ep, sie_in_data}),
      .out_valid(b_valid),
      .out_ready(take_in),
      .out_data({b_ep, b_data})
   );

   assign sel = cmd_q[`BIT_SEL_LOW];
   assign cmd_wr = bus.wr && (bus.addr == `OFS_CMD_STATUS);
   assign data_hit = (bus.addr == `OFS_CTRL_DATA) || (bus.addr == `OFS_INTR_DATA);
   assign port_sel = (bus.addr == `OFS_INTR_DATA);
   // Reads stop at the received length, writes at capacity.
   assign lim = cmd_q[`BIT_TX] ? PW'(DEPTH) : len_q[sel];
   // Ready needs a request, a free endpoint and room left.
   assign ready = cmd_q[`BIT_REQUEST] && !(sel ? sie_busy_intr : sie_busy_ctrl) && (ptr_q[sel] < lim);
   // Only accesses to the selected port while ready count.
   assign acc = ready && data_hit && (port_sel == sel) && (bus.wr || bus.rd);
   // Engine bytes move in only while firmware is away and the buffer has room.
   // A byte that cannot be stored stays staged instead of being popped and lost.
   assign take_in = !cmd_q[`BIT_REQUEST] && !cmd_wr && !sie_take && (len_q[b_ep] < PW'(DEPTH));

   // Command bits held by firmware; the clear bit is a one-shot action.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cmd_q <= 8'h00;
      end else if (cmd_wr) begin
         cmd_q <= {3'h0, bus.wdata[4:0] & 5'h1b};
      end
   end

   // Buffer pointers and lengths.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ptr_q <= '{default: '0};
         len_q <= '{default: '0};
      end else begin
         if (cmd_wr && bus.wdata[`BIT_CLEAR]) begin
            len_q[bus.wdata[`BIT_SEL_LOW]] <= '0;
            ptr_q[bus.wdata[`BIT_SEL_LOW]] <= '0;
         end else if (cmd_wr && bus.wdata[`BIT_REQUEST] && !cmd_q[`BIT_REQUEST]) begin
            ptr_q[bus.wdata[`BIT_SEL_LOW]] <= '0;
         end else if (cmd_wr && !bus.wdata[`BIT_REQUEST] && cmd_q[`BIT_REQUEST]) begin
            // Direction low at the drop ends a write, high ends a read.
            if (req_tx_q && !cmd_q[`BIT_TX]) begin
               len_q[sel] <= ptr_q[sel];
            end else if (!req_tx_q && cmd_q[`BIT_TX] && (ptr_q[sel] != '0)) begin
               // A read that took bytes consumes the packet; a bare readiness check keeps it.
               len_q[sel] <= '0;
            end
         end else if (acc) begin
            ptr_q[sel] <= PW'(ptr_q[sel] + 1'b1);
         end else if (b_valid && take_in) begin
            len_q[b_ep] <= PW'(len_q[b_ep] + 1'b1);
         end
         if (sie_take) begin
            len_q[sie_take_ep] <= '0;
         end
      end
   end

   // Direction in force when the request went up. The drop alone cannot tell a write end
   // from a read readiness check, since both leave the direction bit low.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         req_tx_q <= 1'b0;
      end else if (cmd_wr && bus.wdata[`BIT_REQUEST] && !cmd_q[`BIT_REQUEST]) begin
         req_tx_q <= bus.wdata[`BIT_TX];
      end
   end

   // Byte storage.
   always_ff @(posedge clock) begin
      if (acc && bus.wr) begin
         mem_q[sel][ptr_q[sel][$clog2(DEPTH)-1:0]] <= bus.wdata;
      end else if (b_valid && take_in) begin
         mem_q[b_ep][len_q[b_ep][$clog2(DEPTH)-1:0]] <= b_data;
      end
   end

   // Setup and zero-length flags; the hardware set wins over a clear in the same cycle.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         setup_q <= 1'b0;
         zlen_q <= 1'b0;
      end else begin
         if (sie_setup) begin
            setup_q <= 1'b1;
         end else if (cmd_wr && !bus.wdata[`BIT_SETUP]) begin
            setup_q <= 1'b0;
         end
         if (sie_zero_len) begin
            zlen_q <= 1'b1;
         end else if (sie_setup) begin
            zlen_q <= 1'b0;
         end else if (acc && bus.rd) begin
            zlen_q <= 1'b0;
         end else if (cmd_wr && !bus.wdata[`BIT_ZLEN]) begin
            zlen_q <= 1'b0;
         end
      end
   end

   // Completion interrupt, endpoint number and accessed bitmap.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         int_q <= 1'b0;
         aen_q <= 1'b0;
         bitmap_q <= 2'h0;
      end else begin
         int_q <= sie_done;
         if (sie_done) begin
            aen_q <= sie_done_ep;
            bitmap_q[sie_done_ep] <= 1'b1;
         end
      end
   end

   // Registered read data; unmapped addresses read zero.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
         sout_q <= 8'h00;
      end else begin
         sout_q <= mem_q[sie_take_ep][0];
         if (bus.addr == `OFS_CMD_STATUS) begin
            rdata_q <= {zlen_q, ready, setup_q, cmd_q[4:0]};
         end else if (data_hit) begin
            rdata_q <= acc ? mem_q[sel][ptr_q[sel][$clog2(DEPTH)-1:0]] : 8'h00;
         end else begin
            rdata_q <= 8'h00;
         end
      end
   end

   assign bus.rdata = rdata_q;
   assign sie_out_data = sout_q;
   assign usb_int = int_q;
   assign accessed_endpoint_number = aen_q;
   assign accessed_bitmap = bitmap_q;
endmodule

// ### fifo_port_mcu.sv
// Processor end: runs packet read and write sequences over the register link.
`timescale 1ns/1ns
`include "fifo_port_defs.svh"
module fifo_port_mcu #(
   parameter int WAIT = `WAIT_CYCLES
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_n,
   // Register link.
   fifo_port_if.mcu bus,
   // User command.
   input wire logic start,
   input wire logic write,
   input wire logic endpoint,
   input wire logic [3:0] count,
   input fifo_port_pkg::byte_t wbyte,
   output logic busy,
   output fifo_port_pkg::byte_t rbyte,
   output logic rbyte_valid
);
   import fifo_port_pkg::*;

   host_st_t st_q;
   logic [15:0] tmr_q;
   logic [3:0] n_q;
   logic wr_q, rd_q, dir_q, ep_q, pend_q, arm_q, rdl_q;
   addr_t addr_q;
   byte_t wd_q, rb_q;
   logic rv_q;
   byte_t base;

   assign base = {3'h0, 1'b0, ep_q, 1'b0, dir_q, 1'b0};

   // Sequence: set direction, raise request, wait 2 us, poll ready, move a byte every 2 us.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= ST_IDLE;
         tmr_q <= 16'h0000;
         n_q <= 4'h0;
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         dir_q <= 1'b0;
         ep_q <= 1'b0;
         pend_q <= 1'b0;
         arm_q <= 1'b0;
         rdl_q <= 1'b0;
         addr_q <= 8'h00;
         wd_q <= 8'h00;
         rb_q <= 8'h00;
         rv_q <= 1'b0;
      end else begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         rv_q <= 1'b0;
         case (st_q)
            ST_IDLE: begin
               if (start) begin
                  dir_q <= write;
                  ep_q <= endpoint;
                  n_q <= (count > 4'h8) ? 4'h8 : count;
                  wr_q <= 1'b1;
                  addr_q <= `OFS_CMD_STATUS;
                  wd_q <= {3'h0, 1'b0, endpoint, 1'b0, write, 1'b0};
                  arm_q <= 1'b1;
                  st_q <= ST_WR;
               end
            end
            ST_WAIT: begin
               if (tmr_q != 16'h0000) begin
                  tmr_q <= 16'(tmr_q - 1'b1);
               end else begin
                  rd_q <= 1'b1;
                  addr_q <= `OFS_CMD_STATUS;
                  st_q <= ST_RD;
               end
            end
            ST_RD: begin
               if (!pend_q) begin
                  pend_q <= 1'b1;
               end else begin
                  pend_q <= 1'b0;
                  if (!bus.rdata[`BIT_READY] || (dir_q && n_q == 4'h0)) begin
                     // Finish: flip direction, then drop request.
                     wr_q <= 1'b1;
                     addr_q <= `OFS_CMD_STATUS;
                     wd_q <= base ^ 8'h02 | 8'h01;
                     st_q <= ST_WR;
                  end else begin
                     wr_q <= dir_q;
                     rd_q <= !dir_q;
                     addr_q <= ep_q ? `OFS_INTR_DATA : `OFS_CTRL_DATA;
                     wd_q <= wbyte;
                     n_q <= (n_q != 4'h0) ? 4'(n_q - 1'b1) : 4'h0;
                     tmr_q <= 16'(WAIT);
                     st_q <= ST_WAIT;
                  end
               end
            end
            ST_WR: begin
               wr_q <= 1'b1;
               addr_q <= `OFS_CMD_STATUS;
               if (arm_q) begin
                  // Request rises only once direction and select already stand.
                  arm_q <= 1'b0;
                  wd_q <= base | 8'h01;
                  tmr_q <= 16'(WAIT);
                  st_q <= ST_WAIT;
               end else begin
                  wd_q <= base ^ 8'h02;
                  st_q <= ST_IDLE;
               end
            end
            default: begin
               st_q <= ST_IDLE;
            end
         endcase
         // Read data stands for one cycle only, two edges after the data port strobe went out.
         rdl_q <= rd_q && (addr_q != `OFS_CMD_STATUS);
         if (rdl_q) begin
            rb_q <= bus.rdata;
            rv_q <= 1'b1;
         end
      end
   end

   assign bus.wr = wr_q;
   assign bus.rd = rd_q;
   assign bus.addr = addr_q;
   assign bus.wdata = wd_q;
   assign busy = (st_q != ST_IDLE);
   assign rbyte = rb_q;
   assign rbyte_valid = rv_q;
endmodule

// ### fifo_port_monitor.sv
// Checker for the register link between the processor end and the device end.
`timescale 1ns/1ns
module fifo_port_monitor #(
   parameter int WAIT = 100
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_n,
   // Register link.
   input wire logic wr,
   input wire logic rd,
   input fifo_port_pkg::addr_t addr,
   input fifo_port_pkg::byte_t wdata,
   input fifo_port_pkg::byte_t rdata
);
   import fifo_port_pkg::*;
   logic [4:0] cmd_q;
   logic [9:0] cg_q;
   logic [9:0] dg_q;
   logic [3:0] n_q;
   logic cw;
   logic dacc;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   // Decode command writes and data port strobes.
   assign cw = wr && addr == 8'h46;
   assign dacc = (wr || rd) && (addr == 8'h48 || addr == 8'h49);
   // Shadow of the stored command bits; the clear bit acts once and is never kept.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) cmd_q <= 5'h00;
      else if (cw) cmd_q <= {wdata[4:3], 1'b0, wdata[1:0]};
   end
   // Cycles since the last command write, saturating so it never wraps.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) cg_q <= 10'h000;
      else if (cw) cg_q <= 10'h000;
      else if (cg_q != 10'h3ff) cg_q <= cg_q + 10'h001;
   end
   // Cycles since the last data port access; starts saturated so the first access is free.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) dg_q <= 10'h3ff;
      else if (dacc) dg_q <= 10'h000;
      else if (dg_q != 10'h3ff) dg_q <= dg_q + 10'h001;
   end
   // Data accesses made under one request.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) n_q <= 4'h0;
      else if (cw && !wdata[0]) n_q <= 4'h0;
      else if (dacc && n_q != 4'hf) n_q <= n_q + 4'h1;
   end
   property p_echo; rd && addr == 8'h46 |=> rdata[4:0] == cmd_q; endproperty
   a_echo: assert property (p_echo) else $error("status does not echo command");
   property p_poll; rd && addr == 8'h46 && cmd_q[0] |-> cg_q >= WAIT - 1; endproperty
   a_poll: assert property (p_poll) else $error("status polled too early");
   property p_gap; dacc |-> dg_q >= WAIT - 1; endproperty
   a_gap: assert property (p_gap) else $error("data accesses too close");
   property p_wdir; wr && dacc |-> cmd_q[1] && cmd_q[0]; endproperty
   a_wdir: assert property (p_wdir) else $error("data write without write request");
   property p_rdir; rd && dacc |-> !cmd_q[1] && cmd_q[0]; endproperty
   a_rdir: assert property (p_rdir) else $error("data read without read request");
   property p_drop; cw && cmd_q[0] && !wdata[0] |-> wdata[1] == cmd_q[1]; endproperty
   a_drop: assert property (p_drop) else $error("direction changed with request drop");
   property p_port; dacc |-> addr[0] == cmd_q[3]; endproperty
   a_port: assert property (p_port) else $error("data port differs from select");
   property p_count; dacc |-> n_q < 4'h8; endproperty
   a_count: assert property (p_count) else $error("more than eight bytes in a packet");
endmodule

// ### testbench.sv
// Self-checking bench joining the processor end and the device end of the buffer port.
`timescale 1ns/1ns
module testbench;
   import fifo_port_pkg::*;
   localparam int W = 4;
   typedef struct {logic wr; logic ep; int n; byte_t b;} row_t;
   logic clock = 1'b0, rst_n = 1'b0, start = 1'b0, write = 1'b0, endpoint = 1'b0, busy, rbyte_valid;
   logic sie_in_valid = 1'b0, sie_in_ep = 1'b0, sie_busy_ctrl = 1'b0, sie_done = 1'b0, sie_done_ep = 1'b0;
   logic sie_take = 1'b0, sie_take_ep = 1'b0, sie_in_ready, usb_int, accessed_endpoint_number;
   logic [1:0] accessed_bitmap;
   logic sie_busy_intr = 1'b0, sie_setup = 1'b0, sie_zero_len = 1'b0;
   logic [3:0] count = 4'h0;
   byte_t wbyte = 8'h00, sie_in_data = 8'h00, rbyte, sie_out_data;
   byte_t got[$];
   int err_total = 0, n_checks = 0;
   row_t rows[4] = '{'{1'b1, 1'b0, 3, 8'h5a}, '{1'b1, 1'b1, 8, 8'hc3}, '{1'b0, 1'b0, 8, 8'h10}, '{1'b0, 1'b1, 2, 8'h80}};
   // The two ends meet on one link; the checker watches it.
   fifo_port_if fifo_port_if_inst();
   fifo_port_dev fifo_port_dev_inst(.clock(clock), .rst_n(rst_n), .bus(fifo_port_if_inst),
      .sie_in_valid(sie_in_valid), .sie_in_ready(sie_in_ready), .sie_in_ep(sie_in_ep), .sie_in_data(sie_in_data),
      .sie_busy_ctrl(sie_busy_ctrl), .sie_busy_intr(sie_busy_intr), .sie_setup(sie_setup),
      .sie_zero_len(sie_zero_len),
      .sie_done(sie_done), .sie_done_ep(sie_done_ep), .sie_take(sie_take), .sie_take_ep(sie_take_ep),
      .sie_out_data(sie_out_data), .usb_int(usb_int), .accessed_endpoint_number(accessed_endpoint_number),
      .accessed_bitmap(accessed_bitmap));
   fifo_port_mcu #(.WAIT(W)) fifo_port_mcu_inst(.clock(clock), .rst_n(rst_n), .bus(fifo_port_if_inst),
      .start(start), .write(write), .endpoint(endpoint), .count(count), .wbyte(wbyte), .busy(busy),
      .rbyte(rbyte), .rbyte_valid(rbyte_valid));
   fifo_port_monitor #(.WAIT(W)) fifo_port_monitor_inst(.clock(clock), .rst_n(rst_n),
      .wr(fifo_port_if_inst.wr), .rd(fifo_port_if_inst.rd), .addr(fifo_port_if_inst.addr),
      .wdata(fifo_port_if_inst.wdata), .rdata(fifo_port_if_inst.rdata));
   // Free-running 50 MHz clock.
   always #10 clock = ~clock;
   // Count one comparison and report a failure at once.
   task automatic chk(input logic ok, input string msg);
      n_checks++;
      if (!ok) begin
         err_total++;
         $display("MISMATCH at %0t: %s", $time, msg);
      end
   endtask
   // Single exit point of the run.
   task automatic complete_run();
      $display("Checks: %0d, mismatches: %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // A wait that ran out is a mismatch and ends the run.
   task automatic hung();
      err_total++;
      $display("MISMATCH at %0t: wait expired", $time);
      complete_run();
   endtask
   // Engine bytes into a buffer; each byte is held until the buffer takes it.
   task automatic feed(input logic ep, input int n, input byte_t base);
      int t;
      for (int i = 0; i < n; i++) begin
         sie_in_valid = 1'b1;
         sie_in_ep = ep;
         sie_in_data = base + byte_t'(i);
         t = 0;
         while (sie_in_ready !== 1'b1 && t < 50) begin
            @(negedge clock);
            t++;
         end
         if (t == 50) hung();
         @(negedge clock);
      end
      sie_in_valid = 1'b0;
   endtask
   // One processor packet transfer; read bytes are collected until the end stops being busy.
   task automatic run(input logic wr, input logic ep, input logic [3:0] c, input byte_t wb);
      int t;
      got.delete();
      write = wr;
      endpoint = ep;
      count = c;
      wbyte = wb;
      start = 1'b1;
      @(negedge clock);
      start = 1'b0;
      t = 0;
      do begin
         @(negedge clock);
         if (rbyte_valid === 1'b1) got.push_back(rbyte);
         t++;
      end while ((busy === 1'b1 || t < 3) && t < 5000);
      if (t == 5000) hung();
   endtask
   // Host completion: one-cycle interrupt with the endpoint reported.
   task automatic done(input logic ep);
      sie_done = 1'b1;
      sie_done_ep = ep;
      @(negedge clock);
      sie_done = 1'b0;
      chk(usb_int === 1'b1 && accessed_endpoint_number === ep && accessed_bitmap[ep] === 1'b1, "report");
      @(negedge clock);
      chk(usb_int === 1'b0, "interrupt width");
   endtask
   // Main sequence: reset, table rows, then the awkward cases.
   initial begin
      repeat (6) @(negedge clock);
      chk(usb_int === 1'b0 && busy === 1'b0 && accessed_bitmap === 2'h0, "reset values");
      rst_n = 1'b1;
      @(negedge clock);
      foreach (rows[i]) begin
         if (rows[i].wr) begin
            run(1'b1, rows[i].ep, 4'(rows[i].n), rows[i].b);
            sie_take_ep = rows[i].ep;
            repeat (2) @(negedge clock);
            chk(sie_out_data === rows[i].b, "written byte");
            sie_take = 1'b1;
            @(negedge clock);
            sie_take = 1'b0;
         end else begin
            feed(rows[i].ep, rows[i].n, rows[i].b);
            run(1'b0, rows[i].ep, 4'h8, 8'h00);
            chk(got.size() == rows[i].n, "read length");
            foreach (got[k]) chk(got[k] === rows[i].b + byte_t'(k), "read byte");
         end
         done(rows[i].ep);
      end
      // Engine flags, seen in the status byte that the idle link keeps reading back.
      sie_zero_len = 1'b1;
      @(negedge clock);
      sie_zero_len = 1'b0;
      @(negedge clock);
      if (fifo_port_if_inst.rdata[7:5] !== 3'h4) chk(1'b0, "zero-length flag"); else chk(1'b1, "");
      sie_setup = 1'b1;
      @(negedge clock);
      sie_setup = 1'b0;
      @(negedge clock);
      chk(fifo_port_if_inst.rdata[7:5] === 3'h1, "setup clears zero-length");
      // The host owns the control endpoint, so the processor must see it not ready.
      feed(1'b0, 3, 8'h40);
      sie_busy_ctrl = 1'b1;
      run(1'b0, 1'b0, 4'h8, 8'h00);
      chk(got.size() == 0, "host-owned read");
      chk(fifo_port_if_inst.rdata[5] === 1'b0, "firmware clears setup");
      sie_busy_ctrl = 1'b0;
      run(1'b0, 1'b0, 4'h8, 8'h00);
      chk(got.size() == 3 && got[0] === 8'h40, "read after release");
      // Overfill: the staging entries hold the surplus, nothing may be lost.
      feed(1'b1, 10, 8'h20);
      chk(sie_in_ready === 1'b0, "full buffer refuses");
      run(1'b0, 1'b1, 4'h8, 8'h00);
      chk(got.size() == 8 && got[7] === 8'h27, "full packet");
      repeat (4) @(negedge clock);
      sie_busy_intr = 1'b1;
      run(1'b0, 1'b1, 4'h8, 8'h00);
      chk(got.size() == 0, "host-owned interrupt read");
      sie_busy_intr = 1'b0;
      run(1'b0, 1'b1, 4'h8, 8'h00);
      chk(got.size() == 2 && got[1] === 8'h29, "staged bytes kept");
      chk(accessed_bitmap === 2'h3, "bitmap sticky");
      // Mid-run reset: sticky reports, staging and buffer lengths all return to idle.
      rst_n = 1'b0;
      @(negedge clock);
      chk(accessed_bitmap === 2'h0 && usb_int === 1'b0 && busy === 1'b0 && sie_in_ready === 1'b1, "mid-run reset");
      rst_n = 1'b1;
      @(negedge clock);
      run(1'b0, 1'b1, 4'h8, 8'h00);
      chk(got.size() == 0, "reset empties buffer");
      complete_run();
   end
endmodule
